// ===== logic/spi_port.sv
/*
 * Four-wire serial peripheral port, master or slave, with sticky status
 * flags and a two-entry receive buffer toward the processor.
 * Assumes control and configuration inputs come from logic on CORE_CLK;
 * the four pins come from outside and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

`include "spi_params.svh"

module spi_port
   import spi_port_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RSTN,
   input  wire logic        SCK_IN,
   output logic             SCK_OUT,
   output logic             SCK_OE,
   input  wire logic        MOSI_IN,
   output logic             MOSI_OUT,
   output logic             MOSI_OE,
   input  wire logic        MISO_IN,
   output logic             MISO_OUT,
   output logic             MISO_OE,
   input  wire logic        SLAVE_SELECT_LOW,
   input  wire logic        CTRL_WR,
   input  wire logic        CTRL_MASTER_ENABLE,
   input  wire logic        CTRL_PORT_ENABLE,
   input  wire logic        CLOCK_PHASE,
   input  wire logic        CLOCK_POLARITY,
   input  wire logic [2:0]  FRAME_SIZE,
   input  wire logic [7:0]  CLOCK_DIVIDER,
   input  wire logic        INT_ENABLE,
   input  wire logic        DATA_WR,
   input  wire logic [7:0]  DATA_IN,
   output logic [7:0]       RX_DATA,
   output logic             RX_VALID,
   input  wire logic        RX_READY,
   input  wire logic [3:0]  FLAG_CLEAR,
   output logic             TRANSFER_DONE,
   output logic             WRITE_COLLISION,
   output logic             RECEIVE_OVERRUN,
   output logic             MODE_FAULT,
   output logic             SLAVE_SELECTED,
   output logic             MASTER_ENABLE,
   output logic             PORT_ENABLE,
   output logic             BUSY,
   output logic             IRQ
);

   state_type s;
   state_type next_s;
   logic      buf_ready;

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------

   // phase zero presents the first bit before the first edge
   function automatic logic [8:0] load_shift(input logic [7:0] word, input logic cpha);
      logic [8:0] r;
      r = {1'b0, word};
      if (!cpha) begin
         r = {word[7], word[6:0], 1'b0};
      end
      return r;
   endfunction

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb begin
      logic       set_done;
      logic       set_write_collision_flag;
      logic       set_ovr;
      logic       set_mode_fault_flag;
      logic       lead;
      logic       sample;
      logic [8:0] ld;
      logic [7:0] word;
      set_done = 1'b0;
      set_write_collision_flag = 1'b0;
      set_ovr  = 1'b0;
      set_mode_fault_flag = 1'b0;
      lead     = 1'b0;
      sample   = 1'b0;
      ld       = 9'h000;
      word     = 8'h00;
      next_s      = s;
      next_s.push = 1'b0;

      // pins pass two flops before anything reads them; s3 only for edges
      next_s.sck_s1  = SCK_IN;
      next_s.sck_s2  = s.sck_s1;
      next_s.sck_s3  = s.sck_s2;
      // slave sampling trails the pins by two flops, which is what limits the
      // external master to a tenth (full duplex) or a quarter (receive only)
      next_s.mosi_s1 = MOSI_IN;
      next_s.mosi_s2 = s.mosi_s1;
      next_s.miso_s1 = MISO_IN;
      next_s.miso_s2 = s.miso_s1;
      next_s.sel_s1  = !SLAVE_SELECT_LOW;
      next_s.sel_s2  = s.sel_s1;
      next_s.slave_selected_flag  = s.sel_s2;

      if (CTRL_WR) begin
         next_s.master_enable_bit = CTRL_MASTER_ENABLE;
         next_s.port_enable_bit = CTRL_PORT_ENABLE;
      end
      // another master selected us while we were master: go off-line
      if (s.master_enable_bit && s.port_enable_bit && s.sel_s2) begin
         set_mode_fault_flag     = 1'b1;
         next_s.master_enable_bit = 1'b0;
         next_s.port_enable_bit = 1'b0;
      end

      // writes during any transfer are dropped, the transfer runs on
      if (DATA_WR && s.phase != ST_IDLE) begin
         set_write_collision_flag = 1'b1;
      end

      case (s.phase)
         ST_IDLE: begin
            next_s.sck     = CLOCK_POLARITY;
            next_s.sck_oe  = next_s.master_enable_bit && next_s.port_enable_bit;
            next_s.mosi_oe = next_s.master_enable_bit && next_s.port_enable_bit;
            next_s.miso_oe = 1'b0;
            if (DATA_WR && s.master_enable_bit && s.port_enable_bit && !set_mode_fault_flag) begin
               // left-align the frame so its top bit leaves first
               ld             = load_shift(DATA_IN << ~FRAME_SIZE, CLOCK_PHASE);
               next_s.mosi    = ld[8];
               next_s.tx      = ld[7:0];
               next_s.rx      = 8'h00;
               next_s.div_cnt = 8'h00;
               next_s.edge_cnt = 4'h0;
               next_s.frame   = FRAME_SIZE;
               next_s.cpha    = CLOCK_PHASE;
               next_s.cpol    = CLOCK_POLARITY;
               next_s.phase   = ST_MASTER;
            end else begin
               if (DATA_WR) begin
                  next_s.slave_tx = DATA_IN;
               end
               // a write in this same cycle is too late: old word goes out
               if (s.port_enable_bit && !s.master_enable_bit && s.sel_s2) begin
                  ld             = load_shift(s.slave_tx, CLOCK_PHASE);
                  next_s.miso    = ld[8];
                  next_s.tx      = ld[7:0];
                  next_s.rx      = 8'h00;
                  next_s.bit_cnt = 3'h0;
                  next_s.cpha    = CLOCK_PHASE;
                  next_s.cpol    = CLOCK_POLARITY;
                  next_s.miso_oe = 1'b1;
                  next_s.sck_oe  = 1'b0;
                  next_s.mosi_oe = 1'b0;
                  next_s.phase   = ST_SLAVE;
               end
            end
         end

         ST_MASTER: begin
            if (!next_s.master_enable_bit || !next_s.port_enable_bit) begin
               next_s.sck   = s.cpol;
               next_s.phase = ST_IDLE;
            end else if (s.div_cnt >= CLOCK_DIVIDER) begin
               // one serial clock edge per divider+1 system clocks
               next_s.div_cnt = 8'h00;
               next_s.sck     = !s.sck;
               lead           = !s.edge_cnt[0];
               sample         = lead ^ s.cpha;
               if (sample) begin
                  next_s.rx = {s.rx[6:0], s.miso_s2};
               end else begin
                  next_s.mosi = s.tx[7];
                  next_s.tx   = {s.tx[6:0], 1'b0};
               end
               if (s.edge_cnt == {s.frame, 1'b1}) begin
                  next_s.phase = ST_FINISH;
               end else begin
                  next_s.edge_cnt = s.edge_cnt + 4'h1;
               end
            end else begin
               next_s.div_cnt = s.div_cnt + 8'h01;
            end
         end

         ST_FINISH: begin
            // hand the word to the receive buffer unless it is full
            if (buf_ready) begin
               next_s.push      = 1'b1;
               next_s.push_data = s.rx;
            end else begin
               set_ovr = 1'b1;
            end
            set_done     = 1'b1;
            next_s.phase = ST_IDLE;
         end

         ST_SLAVE: begin
            next_s.sck_oe  = 1'b0;
            next_s.mosi_oe = 1'b0;
            if (!next_s.port_enable_bit || next_s.master_enable_bit) begin
               next_s.miso_oe = 1'b0;
               next_s.phase   = ST_IDLE;
            end else if (!s.sel_s2) begin
               // select released: the frame is over
               set_done       = 1'b1;
               next_s.miso_oe = 1'b0;
               next_s.phase   = ST_IDLE;
            end else if (s.sck_s2 != s.sck_s3) begin
               lead   = s.sck_s2 != s.cpol;
               sample = lead ^ s.cpha;
               if (sample) begin
                  word           = {s.rx[6:0], s.mosi_s2};
                  next_s.rx      = word;
                  next_s.bit_cnt = s.bit_cnt + 3'h1;
                  if (s.bit_cnt == `SLAVE_LAST_BIT) begin
                     if (buf_ready) begin
                        next_s.push      = 1'b1;
                        next_s.push_data = word;
                     end else begin
                        set_ovr = 1'b1;
                     end
                  end
               end else begin
                  next_s.miso = s.tx[7];
                  next_s.tx   = {s.tx[6:0], 1'b0};
               end
            end
         end

         default: begin
            next_s.phase = ST_IDLE;
         end
      endcase

      // sticky flags: a set in the clearing cycle wins
      next_s.done = set_done | (s.done & !FLAG_CLEAR[`FLAG_DONE_BIT]);
      next_s.write_collision_flag = set_write_collision_flag | (s.write_collision_flag & !FLAG_CLEAR[`FLAG_WRITE_COLLISION_FLAG_BIT]);
      next_s.ovr  = set_ovr  | (s.ovr  & !FLAG_CLEAR[`FLAG_OVRN_BIT]);
      next_s.mode_fault_flag = set_mode_fault_flag | (s.mode_fault_flag & !FLAG_CLEAR[`FLAG_MODE_FAULT_FLAG_BIT]);
      next_s.irq  = next_s.done & INT_ENABLE;
      next_s.busy = next_s.phase != ST_IDLE;
   end

   // ----------------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------------------
   // receive buffer: a stalled reader fills it, then overrun drops words
   // ----------------------------------------------------------------------------
   rx_word_buffer #(
      .WIDTH (`FRAME_WIDTH)
   ) u_rx_buffer (
      .clk       (CORE_CLK),
      .rstn      (RSTN),
      .in_valid  (s.push),
      .in_data   (s.push_data),
      .in_ready  (buf_ready),
      .out_valid (RX_VALID),
      .out_data  (RX_DATA),
      .out_ready (RX_READY)
   );

   // ----------------------------------------------------------------------------
   // outputs, all straight from state flops
   // ----------------------------------------------------------------------------
   assign SCK_OUT         = s.sck;
   assign SCK_OE          = s.sck_oe;
   assign MOSI_OUT        = s.mosi;
   assign MOSI_OE         = s.mosi_oe;
   assign MISO_OUT        = s.miso;
   assign MISO_OE         = s.miso_oe;
   assign TRANSFER_DONE   = s.done;
   assign WRITE_COLLISION = s.write_collision_flag;
   assign RECEIVE_OVERRUN = s.ovr;
   assign MODE_FAULT      = s.mode_fault_flag;
   assign SLAVE_SELECTED  = s.slave_selected_flag;
   assign MASTER_ENABLE   = s.master_enable_bit;
   assign PORT_ENABLE     = s.port_enable_bit;
   assign BUSY            = s.busy;
   assign IRQ             = s.irq;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RSTN);

   // toggles of the serial clock during one master transfer
   logic [4:0] tog_cnt;
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN || s.phase == ST_IDLE) begin
         tog_cnt <= 5'h00;
      end else if (s.phase == ST_MASTER && next_s.sck != s.sck) begin
         tog_cnt <= tog_cnt + 5'h01;
      end
   end

   a_sck_half_rate: assert property (
      (s.phase == ST_MASTER && CLOCK_DIVIDER != 8'h00 && $changed(SCK_OUT))
      |=> !$changed(SCK_OUT))
      else $error("serial clock toggled on two adjacent cycles");

   a_frame_length: assert property (
      (s.phase == ST_FINISH) |-> (tog_cnt == {({2'b00, s.frame} + 4'h1), 1'b0}))
      else $error("master frame edge count wrong");

   a_msb_first_out: assert property (
      (DATA_WR && s.phase == ST_IDLE && s.master_enable_bit && s.port_enable_bit && !s.sel_s2 && !CLOCK_PHASE)
      |=> (MOSI_OUT == $past(DATA_IN[FRAME_SIZE])))
      else $error("first master bit is not the frame top bit");

   a_miso_release: assert property (
      !$past(s.sel_s2) |-> !MISO_OE)
      else $error("slave output driven while not selected");

   a_write_collision_flag_busy: assert property (
      (DATA_WR && BUSY) |=> (WRITE_COLLISION && $stable(s.frame)))
      else $error("write during transfer not flagged");

   a_mode_fault: assert property (
      (MASTER_ENABLE && PORT_ENABLE && s.sel_s2)
      |=> (MODE_FAULT && !MASTER_ENABLE && !PORT_ENABLE))
      else $error("mode fault not taken");

   a_master_done_irq: assert property (
      (s.phase == ST_FINISH && INT_ENABLE) |=> (TRANSFER_DONE && IRQ))
      else $error("master done or interrupt missing");

   a_overrun_keep: assert property (
      (s.phase == ST_FINISH && !buf_ready) |=> (RECEIVE_OVERRUN && !s.push) ##1 $stable(RX_DATA))
      else $error("overrun not flagged or word not dropped");

   a_slave_done: assert property (
      (s.phase == ST_SLAVE && !s.sel_s2 && s.port_enable_bit && !s.master_enable_bit) |=> TRANSFER_DONE)
      else $error("slave done missing after select release");

   a_slave_flag: assert property (
      SLAVE_SELECTED == !$past(SLAVE_SELECT_LOW, 3))
      else $error("slave selected flag does not follow select");

   a_sck_idle: assert property (
      (s.phase == ST_IDLE && $past(s.phase) == ST_IDLE && s.sck_oe)
      |-> (SCK_OUT == $past(CLOCK_POLARITY)))
      else $error("idle serial clock level wrong");

   a_flag_sticky: assert property (
      (RECEIVE_OVERRUN && !FLAG_CLEAR[`FLAG_OVRN_BIT]) |=> RECEIVE_OVERRUN)
      else $error("overrun flag cleared without software");

endmodule

`default_nettype wire

// ===== logic/spi_params.svh
/*
 * Constants for the serial peripheral port: frame width, flag positions in
 * the software clear vector and reset values of the control bits.
 * Assumes it is included by bare name from the package and the port module.
 */
`ifndef SPI_PARAMS_SVH
`define SPI_PARAMS_SVH

// ----------------------------------------------------------------------------
// frame and counts
// ----------------------------------------------------------------------------
`define FRAME_WIDTH        8
`define SLAVE_LAST_BIT     3'h7
`define CORE_CLK_PERIOD_NS 50

// ----------------------------------------------------------------------------
// bit positions in the flag clear vector
// ----------------------------------------------------------------------------
`define FLAG_DONE_BIT      0
`define FLAG_WRITE_COLLISION_FLAG_BIT      1
`define FLAG_OVRN_BIT      2
`define FLAG_MODE_FAULT_FLAG_BIT      3
`define FLAG_COUNT         4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_MASTER_ENABLE  1'b0
`define RST_PORT_ENABLE    1'b0

`endif

// ===== logic/spi_port_pkg.sv
/*
 * Types shared by the serial peripheral port: the transfer phase and the
 * packed state record of the port.
 * Assumes spi_params.svh is on the include path.
 */
`include "spi_params.svh"

package spi_port_pkg;

   // -------------------------------------------------------------------------
   // transfer phases
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_MASTER = 2'b01,
      ST_FINISH = 2'b10,
      ST_SLAVE  = 2'b11
   } phase_type;

   // -------------------------------------------------------------------------
   // complete state of the port
   // -------------------------------------------------------------------------
   typedef struct packed {
      phase_type                 phase;
      logic                      master_enable_bit;
      logic                      port_enable_bit;
      logic [`FRAME_WIDTH-1:0]   tx;
      logic [`FRAME_WIDTH-1:0]   rx;
      logic [`FRAME_WIDTH-1:0]   slave_tx;
      logic [`FRAME_WIDTH-1:0]   push_data;
      logic                      push;
      logic [7:0]                div_cnt;
      logic [3:0]                edge_cnt;
      logic [2:0]                bit_cnt;
      logic [2:0]                frame;
      logic                      cpha;
      logic                      cpol;
      logic                      sck;
      logic                      sck_oe;
      logic                      mosi;
      logic                      mosi_oe;
      logic                      miso;
      logic                      miso_oe;
      logic                      sck_s1;
      logic                      sck_s2;
      logic                      sck_s3;
      logic                      mosi_s1;
      logic                      mosi_s2;
      logic                      miso_s1;
      logic                      miso_s2;
      logic                      sel_s1;
      logic                      sel_s2;
      logic                      slave_selected_flag;
      logic                      done;
      logic                      write_collision_flag;
      logic                      ovr;
      logic                      mode_fault_flag;
      logic                      busy;
      logic                      irq;
   } state_type;

endpackage

// ===== logic/rx_word_buffer.sv
/*
 * Two-entry receive buffer with valid and ready on both sides. The head
 * entry drives the outputs straight from flip-flops.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module rx_word_buffer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);

   typedef struct packed {
      logic [WIDTH-1:0] head;
      logic [WIDTH-1:0] tail;
      logic             head_valid;
      logic             tail_valid;
   } buf_type;

   buf_type s;
   buf_type next_s;

   // ----------------------------------------------------------------------------
   // next state: pop moves tail to head, push fills the first free entry
   // ----------------------------------------------------------------------------
   always_comb begin
      next_s = s;
      if (s.head_valid && out_ready) begin
         next_s.head       = s.tail;
         next_s.head_valid = s.tail_valid;
         next_s.tail_valid = 1'b0;
      end
      // a push while full is refused even if a pop frees room this cycle
      if (in_valid && !s.tail_valid) begin
         if (!next_s.head_valid) begin
            next_s.head       = in_data;
            next_s.head_valid = 1'b1;
         end else begin
            next_s.tail       = in_data;
            next_s.tail_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign in_ready  = !s.tail_valid;
   assign out_valid = s.head_valid;
   assign out_data  = s.head;

endmodule

`default_nettype wire

// ===== dv/spi_slave_model.sv
/*
 * Behavioural serial slave facing the port in master mode, clock mode 0 only.
 * Assumes its clock and data inputs are the resolved bus wires.
 */
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model (
   input  wire logic       sck,
   input  wire logic       sck_oe,
   input  wire logic       mosi,
   input  wire logic       load,
   input  wire logic [7:0] load_data,
   output logic            miso,
   output logic [7:0]      got
);
   logic [7:0] sr;

   // reply word is preset by the bench before each frame
   always @(posedge load) sr = load_data;
   // sample on the leading edge, msb first
   always @(posedge sck) got = {got[6:0], mosi};
   // shift on the trailing edge only while the master drives the clock
   always @(negedge sck) if (sck_oe) sr = {sr[6:0], 1'b0};
   // released line shows the inverse so a stale bit cannot pass for data
   assign miso = sck_oe ? sr[7] : ~sr[7];
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the serial port: master frames, collision,
 * overrun, mode fault and external-master slave frames in two clock modes.
 * Assumes the port and the slave model compile before it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import spi_port_pkg::*;
   logic CORE_CLK = 1'b0, RSTN = 1'b0, SCK_IN, SCK_OUT, SCK_OE, MOSI_IN, MOSI_OUT, MOSI_OE;
   logic MISO_IN, MISO_OUT, MISO_OE, SLAVE_SELECT_LOW = 1'b1, CTRL_WR = 1'b0;
   logic CTRL_MASTER_ENABLE = 1'b0, CTRL_PORT_ENABLE = 1'b0, DATA_WR = 1'b0, RX_READY = 1'b0;
   logic CLOCK_PHASE = 1'b0, CLOCK_POLARITY = 1'b0, INT_ENABLE = 1'b1;
   logic [2:0] FRAME_SIZE = 3'h7;
   logic [7:0] CLOCK_DIVIDER = 8'h03, DATA_IN = 8'h00, RX_DATA, pl_data = 8'h00, pl_got;
   logic [3:0] FLAG_CLEAR = 4'h0;
   logic TRANSFER_DONE, WRITE_COLLISION, RECEIVE_OVERRUN, MODE_FAULT, SLAVE_SELECTED;
   logic MASTER_ENABLE, PORT_ENABLE, BUSY, IRQ, RX_VALID, pl_miso, pl_load = 1'b0;
   logic ext_sck = 1'b0, ext_mosi = 1'b0;
   int failures = 0, n_compared = 0;

   // resolve each shared wire from the port's output enable alone; otherwise the bench or the slave model drives it
   assign SCK_IN = SCK_OE ? SCK_OUT : ext_sck;
   assign MOSI_IN = MOSI_OE ? MOSI_OUT : ext_mosi;
   assign MISO_IN = MISO_OE ? MISO_OUT : pl_miso;
   always #25 CORE_CLK = ~CORE_CLK;

   spi_port spi_port_inst (.*);
   spi_slave_model spi_slave_model_inst (.sck(SCK_IN), .sck_oe(SCK_OE), .mosi(MOSI_IN),
      .load(pl_load), .load_data(pl_data), .miso(pl_miso), .got(pl_got));

   task automatic tick();
      @(posedge CORE_CLK);
   endtask

   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic ctrl(logic m, logic p);
      CTRL_MASTER_ENABLE <= m;
      CTRL_PORT_ENABLE <= p;
      CTRL_WR <= 1'b1;
      tick();
      CTRL_WR <= 1'b0;
      tick();
   endtask

   task automatic pop(logic [7:0] exp);
      int n;
      n = 0;
      while (RX_VALID !== 1'b1 && n < 50) begin
         tick();
         n++;
      end
      check("rx word", exp, RX_DATA);
      RX_READY <= 1'b1;
      tick();
      RX_READY <= 1'b0;
      tick();
   endtask

   // mode 1 adds a write in mid-frame, mode 2 leaves the word unread
   task automatic xfer(logic [7:0] d, logic [2:0] fs, logic [7:0] dv, logic [7:0] slv, int mode);
      int cnt;
      logic [7:0] m;
      m = 8'hff >> (3'h7 - fs);
      FRAME_SIZE <= fs;
      CLOCK_DIVIDER <= dv;
      pl_data <= slv;
      pl_load <= 1'b1;
      DATA_IN <= d;
      DATA_WR <= 1'b1;
      tick();
      pl_load <= 1'b0;
      DATA_WR <= 1'b0;
      DATA_IN <= ~d;
      tick();
      @(negedge CORE_CLK);
      check("busy", 8'h01, 8'(BUSY));
      cnt = 0;
      while (TRANSFER_DONE !== 1'b1 && cnt < 3000) begin
         tick();
         cnt++;
         DATA_WR <= (mode == 1 && cnt == 3);
         @(negedge CORE_CLK);
      end
      check("done cycles", 8'(2 * (fs + 1) * (dv + 1)), 8'(cnt));
      @(negedge CORE_CLK);
      check("busy off", 8'h00, 8'(BUSY));
      check("irq", 8'h01, 8'(IRQ));
      if (mode == 1) check("collision", 8'h01, 8'(WRITE_COLLISION));
      check("sent", d & m, pl_got & m);
      tick();
      FLAG_CLEAR <= 4'h3;
      tick();
      FLAG_CLEAR <= 4'h0;
      if (mode != 2) pop(slv >> (3'h7 - fs));
   endtask

   task automatic t_master();
      check("selected idle", 8'h00, 8'(SLAVE_SELECTED));
      ctrl(1'b1, 1'b1);
      for (int i = 0; i < 8; i++) xfer(8'h5a + 8'(i), 3'(i), 8'h03, 8'hc3, 0);
      xfer(8'ha5, 3'h7, 8'h05, 8'h96, 1);
      $display("test master done");
   endtask

   task automatic t_overrun();
      xfer(8'h11, 3'h7, 8'h03, 8'ha1, 2);
      xfer(8'h22, 3'h7, 8'h03, 8'hb2, 2);
      xfer(8'h33, 3'h7, 8'h03, 8'hc3, 2);
      check("overrun", 8'h01, 8'(RECEIVE_OVERRUN));
      pop(8'ha1);
      pop(8'hb2);
      check("drained", 8'h00, 8'(RX_VALID));
      $display("test overrun done");
   endtask

   task automatic t_fault();
      SLAVE_SELECT_LOW <= 1'b0;
      repeat (6) tick();
      check("mode fault", 8'h01, 8'(MODE_FAULT));
      check("enables", 8'h00, {6'h00, MASTER_ENABLE, PORT_ENABLE});
      check("selected", 8'h01, 8'(SLAVE_SELECTED));
      SLAVE_SELECT_LOW <= 1'b1;
      repeat (6) tick();
      check("fault held", 8'h01, 8'(MODE_FAULT));
      FLAG_CLEAR <= 4'h8;
      tick();
      FLAG_CLEAR <= 4'h0;
      tick();
      check("fault cleared", 8'h00, 8'(MODE_FAULT));
      $display("test fault done");
   endtask

   // external master at a tenth of the system clock in phase zero and a fifteenth in phase one, select held low throughout
   task automatic t_slave(logic ph, logic pol);
      logic [7:0] seen;
      ctrl(1'b0, 1'b0);
      CLOCK_PHASE <= ph;
      CLOCK_POLARITY <= pol;
      ext_sck <= pol;
      FLAG_CLEAR <= 4'h1;
      ctrl(1'b0, 1'b1);
      FLAG_CLEAR <= 4'h0;
      CLOCK_DIVIDER <= 8'hff;
      DATA_IN <= 8'h3c;
      DATA_WR <= 1'b1;
      tick();
      DATA_WR <= 1'b0;
      repeat (4) tick();
      check("miso off", 8'h00, {6'h00, MISO_OE, SCK_OE});
      SLAVE_SELECT_LOW <= 1'b0;
      repeat (6) tick();
      for (int i = 7; i >= 0; i--) begin
         // phase one shifts on the leading edge and samples on the trailing one
         if (ph) begin
            ext_sck <= !pol;
            repeat (5) tick();
         end
         ext_mosi <= 1'(8'h96 >> i);
         repeat (5) tick();
         seen[i] = MISO_OUT;
         ext_sck <= ph ? pol : !pol;
         repeat (5) tick();
         if (!ph) ext_sck <= pol;
      end
      repeat (5) tick();
      SLAVE_SELECT_LOW <= 1'b1;
      repeat (6) tick();
      check("slave done", 8'h01, 8'(TRANSFER_DONE));
      check("miso released", 8'h00, 8'(MISO_OE));
      check("slave sent", 8'h3c, seen);
      pop(8'h96);
      $display("test slave done");
   endtask

   task automatic results();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      #(50 * 20000);
      failures++;
      results();
   end

   initial begin
      repeat (5) tick();
      RSTN <= 1'b1;
      t_master();
      t_overrun();
      t_fault();
      t_slave(1'b0, 1'b0);
      t_slave(1'b1, 1'b1);
      results();
   end
endmodule

`default_nettype wire
